// *** include/dadp_params.svh ***
// Constants for the dual converter output demultiplex port
// What this block does
// - Prompt bus carries the later sample of each pair, with no extra delay.
// - Delayed bus carries the earlier sample, taken one input clock before.
// - Demultiplex off: both delayed buses are driven to zero with DELAYED_BUS_OE low.
// - Over-range flag is high while the input lies outside half the full scale.
// - Threshold follows the select pin, or the adjust register in extended control.
// - Mirrored data clock is an exact copy of the data clock.
// - Both buses launch with the data clock; the receiver latches with it.
// - Demultiplexed: data clock is half input rate in SDR, quarter in DDR.
// - Not demultiplexed: DDR only, data clock at half the input rate.
// - By default the data clock stops during the resistor trim phase.
// - Trim-disable bit at index 9 skips later trims and keeps the clock running.
// - The power-on calibration always performs the first trim.
// - Extended control is inactive while its enable pin is high, active when low.
// - Calibration indicator stays high while a calibration runs.
// - Code 255 above positive full scale, code 0 below negative full scale.
`ifndef DADP_PARAMS_SVH
`define DADP_PARAMS_SVH
`define DADP_CLK_PERIOD_NS 100
`define DADP_TRIM_TIME_NS 20000
`define DADP_CAL_TIME_NS 100000
`define DADP_IDX_CTRL 4'h0
`define DADP_IDX_FS_ADJ 4'h1
`define DADP_IDX_STATUS 4'h2
`define DADP_IDX_IRQ_STAT 4'h3
`define DADP_IDX_IRQ_CLR 4'h4
`define DADP_IDX_IRQ_EN 4'h5
`define DADP_IDX_EXT_CFG 4'h9
`define DADP_CTRL_DEMUX 0
`define DADP_CTRL_DDR 1
`define DADP_CTRL_CAL 2
`define DADP_EXT_TRIM_DIS 0
`define DADP_CTRL_RESET 32'h0000_0003
`define DADP_EXT_CFG_RESET 16'h0000
`define DADP_FS_ADJ_RESET 16'h0348
`define DADP_FS_LOW_MV 16'h0258
`define DADP_FS_HIGH_MV 16'h0348
`define DADP_IRQ_CAL_DONE 0
`define DADP_IRQ_OVR_I 1
`define DADP_IRQ_OVR_Q 2
`endif

// *** include/dadp_pkg.sv ***
// Types shared by the output demultiplex port
package dadp_pkg;
    typedef enum logic [1:0] {
        CAL_IDLE,
        CAL_TRIM,
        CAL_MAIN
    } dadp_cal_state_t;

    typedef struct packed {
        logic [7:0] prompt;
        logic [7:0] delayed;
    } dadp_pair_t;

    // Highest field first in the status word: bit 0 is calibration done
    typedef struct packed {
        logic ovr_q;
        logic ovr_i;
        logic cal_done;
    } dadp_events_t;
endpackage

// *** hw/dadp_port.sv ***
// Output demultiplex port: data buses, data clocks, over-range and calibration
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "dadp_params.svh"
module dadp_port #(
    parameter int TRIM_CYCLES = (`DADP_TRIM_TIME_NS + `DADP_CLK_PERIOD_NS - 1)
                                / `DADP_CLK_PERIOD_NS,
    parameter int CAL_CYCLES = (`DADP_CAL_TIME_NS + `DADP_CLK_PERIOD_NS - 1)
                               / `DADP_CLK_PERIOD_NS
) (
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic signed [15:0] I_VIN,
    input wire logic signed [15:0] Q_VIN,
    input wire logic FULL_SCALE_SELECT_PIN,
    input wire logic EXTENDED_CTL_ENABLE_PIN,
    input wire logic CAL_REQUEST_PIN,
    output logic [7:0] I_PROMPT_BUS,
    output logic [7:0] Q_PROMPT_BUS,
    output logic [7:0] I_DELAYED_BUS,
    output logic [7:0] Q_DELAYED_BUS,
    output logic DELAYED_BUS_OE,
    output logic DATA_CLOCK_OUT,
    output logic MIRRORED_DATA_CLOCK,
    output logic OVER_RANGE,
    output logic CALIBRATION_ACTIVE_PIN,
    output logic IRQ
);
    localparam int CW = 16;

    // Offset-binary conversion with clamping at both ends of the range
    function automatic logic [7:0] to_code(input logic signed [15:0] vin,
                                           input logic [15:0] fs);
        logic signed [17:0] half;
        logic signed [17:0] v;
        logic [27:0] scaled;
        half = signed'({3'b000, fs[15:1]});
        v = 18'(vin);
        scaled = 28'(((v + half) * 256) / signed'({2'b00, fs}));
        if (v >= half) begin
            to_code = 8'hff;
        end else if (v < -half) begin
            to_code = 8'h00;
        end else if (scaled > 28'h00000ff) begin
            to_code = 8'hff;
        end else begin
            to_code = scaled[7:0];
        end
    endfunction

    function automatic logic out_of_range(input logic signed [15:0] vin,
                                          input logic [15:0] fs);
        logic signed [17:0] half;
        half = signed'({3'b000, fs[15:1]});
        out_of_range = (18'(vin) > half) || (18'(vin) < -half);
    endfunction

    // Shared by write gating and the error flag, so both agree on the map
    function automatic logic reg_mapped(input logic [7:0] addr);
        logic [3:0] idx;
        idx = addr[5:2];
        reg_mapped = 1'b0;
        if (addr[7:6] == 2'h0 && addr[1:0] == 2'h0) begin
            reg_mapped = idx <= `DADP_IDX_IRQ_EN || idx == `DADP_IDX_EXT_CFG;
        end
    endfunction

    // Pin synchronisers
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic cal_pin_last;

    logic [31:0] ctrl;
    logic [15:0] fs_adj;
    logic [15:0] ext_cfg;
    dadp_pkg::dadp_events_t irq_stat;
    dadp_pkg::dadp_events_t irq_en;
    dadp_pkg::dadp_events_t events;

    dadp_pkg::dadp_cal_state_t cal_state;
    logic [CW-1:0] cal_count;
    logic first_cal;
    logic cal_pending;

    logic [7:0] i_early;
    logic [7:0] q_early;
    logic pair_phase;
    logic data_clock_out;
    dadp_pkg::dadp_pair_t i_pair;
    dadp_pkg::dadp_pair_t q_pair;

    logic apb_setup;
    logic apb_write;
    logic [3:0] reg_idx;
    logic ext_active;
    logic demux;
    logic ddr_mode;
    logic trim_disable_bit;
    logic [15:0] fs_mv;
    logic cal_start;
    logic word_strobe;
    logic clock_held;

    assign apb_setup = PSEL && !PENABLE;
    assign apb_write = PSEL && PENABLE && PWRITE && reg_mapped(PADDR);
    assign reg_idx = PADDR[5:2];
    // Reads active for two cycles after reset, until the enable pin has passed the sync
    assign ext_active = !pin_sync[1];
    assign demux = ctrl[`DADP_CTRL_DEMUX];
    assign ddr_mode = ctrl[`DADP_CTRL_DDR] || !demux;
    assign trim_disable_bit = ext_cfg[`DADP_EXT_TRIM_DIS];
    assign fs_mv = ext_active ? fs_adj :
                   (pin_sync[0] ? `DADP_FS_HIGH_MV : `DADP_FS_LOW_MV);
    assign cal_start = cal_state == dadp_pkg::CAL_IDLE && cal_pending;
    assign clock_held = cal_state == dadp_pkg::CAL_TRIM;
    assign word_strobe = !demux || pair_phase;

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
            cal_pin_last <= 1'b0;
        end else begin
            pin_meta <= {CAL_REQUEST_PIN, EXTENDED_CTL_ENABLE_PIN, FULL_SCALE_SELECT_PIN};
            pin_sync <= pin_meta;
            cal_pin_last <= pin_sync[2];
        end
    end

    // Register writes
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            ctrl <= `DADP_CTRL_RESET;
            fs_adj <= `DADP_FS_ADJ_RESET;
            ext_cfg <= `DADP_EXT_CFG_RESET;
            irq_en <= '0;
        end else if (apb_write) begin
            unique case (reg_idx)
                `DADP_IDX_CTRL: ctrl <= {29'h0, 1'b0, PWDATA[1:0]};
                `DADP_IDX_FS_ADJ: begin
                    if (ext_active) begin
                        fs_adj <= PWDATA[15:0];
                    end
                end
                `DADP_IDX_EXT_CFG: begin
                    if (ext_active) begin
                        ext_cfg <= PWDATA[15:0];
                    end
                end
                `DADP_IDX_IRQ_EN: irq_en <= PWDATA[2:0];
                default: ;
            endcase
        end
    end

    // Read data and error are set up in the setup phase, so no wait states
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            PRDATA <= 32'h0;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= 1'b1;
            if (apb_setup) begin
                PSLVERR <= 1'b0;
                unique case (reg_idx)
                    `DADP_IDX_CTRL: PRDATA <= ctrl;
                    `DADP_IDX_FS_ADJ: PRDATA <= {16'h0, fs_adj};
                    `DADP_IDX_STATUS: PRDATA <= {27'h0, ext_active, pin_sync[0],
                                                 first_cal, clock_held,
                                                 cal_state != dadp_pkg::CAL_IDLE};
                    `DADP_IDX_IRQ_STAT: PRDATA <= {29'h0, irq_stat};
                    `DADP_IDX_IRQ_CLR: PRDATA <= 32'h0;
                    `DADP_IDX_IRQ_EN: PRDATA <= {29'h0, irq_en};
                    `DADP_IDX_EXT_CFG: PRDATA <= {16'h0, ext_cfg};
                    default: begin
                        PRDATA <= 32'h0;
                        PSLVERR <= !reg_mapped(PADDR);
                    end
                endcase
                if (PADDR[7:6] != 2'h0 || PADDR[1:0] != 2'h0) begin
                    PSLVERR <= 1'b1;
                    PRDATA <= 32'h0;
                end
            end
        end
    end

    // Calibration sequencer; the power-on run always trims
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            cal_state <= dadp_pkg::CAL_IDLE;
            cal_count <= '0;
            first_cal <= 1'b1;
            cal_pending <= 1'b1;
        end else begin
            if ((pin_sync[2] && !cal_pin_last)
                || (apb_write && reg_idx == `DADP_IDX_CTRL && PWDATA[`DADP_CTRL_CAL])) begin
                cal_pending <= 1'b1;
            end else if (cal_start) begin
                cal_pending <= 1'b0;
            end
            unique case (cal_state)
                dadp_pkg::CAL_IDLE: begin
                    if (cal_pending) begin
                        cal_count <= '0;
                        if (first_cal || !trim_disable_bit) begin
                            cal_state <= dadp_pkg::CAL_TRIM;
                        end else begin
                            cal_state <= dadp_pkg::CAL_MAIN;
                        end
                    end
                end
                dadp_pkg::CAL_TRIM: begin
                    if (cal_count == CW'(TRIM_CYCLES - 1)) begin
                        cal_count <= '0;
                        cal_state <= dadp_pkg::CAL_MAIN;
                    end else begin
                        cal_count <= cal_count + 1'b1;
                    end
                end
                dadp_pkg::CAL_MAIN: begin
                    if (cal_count == CW'(CAL_CYCLES - 1)) begin
                        cal_state <= dadp_pkg::CAL_IDLE;
                        first_cal <= 1'b0;
                    end else begin
                        cal_count <= cal_count + 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            CALIBRATION_ACTIVE_PIN <= 1'b0;
        end else begin
            CALIBRATION_ACTIVE_PIN <= cal_start || (cal_state != dadp_pkg::CAL_IDLE
                && !(cal_state == dadp_pkg::CAL_MAIN
                     && cal_count == CW'(CAL_CYCLES - 1)));
        end
    end

    // Sample pairing: earlier sample waits one input clock for its partner
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            pair_phase <= 1'b0;
            i_early <= 8'h00;
            q_early <= 8'h00;
            i_pair <= '0;
            q_pair <= '0;
        end else begin
            // Phase restarts with demultiplexing, so pairs count from the enabling edge
            pair_phase <= demux ? !pair_phase : 1'b0;
            if (!pair_phase) begin
                i_early <= to_code(I_VIN, fs_mv);
                q_early <= to_code(Q_VIN, fs_mv);
            end
            if (word_strobe) begin
                i_pair.prompt <= to_code(I_VIN, fs_mv);
                q_pair.prompt <= to_code(Q_VIN, fs_mv);
                i_pair.delayed <= demux ? i_early : 8'h00;
                q_pair.delayed <= demux ? q_early : 8'h00;
            end
        end
    end

    // Data clock; demux DDR toggles once per word, otherwise every input clock
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            data_clock_out <= 1'b0;
        end else if (clock_held) begin
            // Parked low, so the pause never leaves the receiver a runt pulse
            data_clock_out <= 1'b0;
        end else if (demux && ddr_mode) begin
            if (word_strobe) begin
                data_clock_out <= !data_clock_out;
            end
        end else begin
            data_clock_out <= !data_clock_out;
        end
    end

    // Outputs registered so buses and clock leave together
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            I_PROMPT_BUS <= 8'h00;
            Q_PROMPT_BUS <= 8'h00;
            I_DELAYED_BUS <= 8'h00;
            Q_DELAYED_BUS <= 8'h00;
            DELAYED_BUS_OE <= 1'b0;
            DATA_CLOCK_OUT <= 1'b0;
            MIRRORED_DATA_CLOCK <= 1'b0;
            OVER_RANGE <= 1'b0;
        end else begin
            I_PROMPT_BUS <= i_pair.prompt;
            Q_PROMPT_BUS <= q_pair.prompt;
            // Gated on the live mode, so the buses fall together with the enable
            if (demux) begin
                I_DELAYED_BUS <= i_pair.delayed;
                Q_DELAYED_BUS <= q_pair.delayed;
            end else begin
                I_DELAYED_BUS <= 8'h00;
                Q_DELAYED_BUS <= 8'h00;
            end
            DELAYED_BUS_OE <= demux;
            DATA_CLOCK_OUT <= data_clock_out;
            MIRRORED_DATA_CLOCK <= data_clock_out;
            OVER_RANGE <= out_of_range(I_VIN, fs_mv) || out_of_range(Q_VIN, fs_mv);
        end
    end

    // Sticky events; a new event wins over a clear in the same cycle
    always_comb begin
        events = '0;
        events.cal_done = cal_state == dadp_pkg::CAL_MAIN
                          && cal_count == CW'(CAL_CYCLES - 1);
        events.ovr_i = out_of_range(I_VIN, fs_mv);
        events.ovr_q = out_of_range(Q_VIN, fs_mv);
    end

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            irq_stat <= '0;
            IRQ <= 1'b0;
        end else begin
            if (apb_write && reg_idx == `DADP_IDX_IRQ_CLR) begin
                irq_stat <= (irq_stat & ~PWDATA[2:0]) | events;
            end else begin
                irq_stat <= irq_stat | events;
            end
            IRQ <= |(irq_stat & irq_en);
        end
    end
endmodule // dadp_port

// *** tb/dadp_port_sva.sv ***
// Pin-level checks of the output demultiplex port
`timescale 1ns/1ps
module dadp_port_sva #(
    parameter int TRIM_CYCLES = 200,
    parameter int CAL_CYCLES = 1000
) (
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic PREADY,
    input wire logic signed [15:0] I_VIN,
    input wire logic FULL_SCALE_SELECT_PIN,
    input wire logic EXTENDED_CTL_ENABLE_PIN,
    input wire logic [7:0] I_PROMPT_BUS,
    input wire logic [7:0] I_DELAYED_BUS,
    input wire logic [7:0] Q_DELAYED_BUS,
    input wire logic DELAYED_BUS_OE,
    input wire logic DATA_CLOCK_OUT,
    input wire logic MIRRORED_DATA_CLOCK,
    input wire logic OVER_RANGE,
    input wire logic CALIBRATION_ACTIVE_PIN
);
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (!RESETN);
    int cal_cnt;
    logic first_cal;
    wire fs_hi = FULL_SCALE_SELECT_PIN && EXTENDED_CTL_ENABLE_PIN;
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            cal_cnt <= 0;
        end else begin
            cal_cnt <= CALIBRATION_ACTIVE_PIN ? cal_cnt + 1 : 0;
        end
    end
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            first_cal <= 1'b1;
        end else if (cal_cnt != 0 && !CALIBRATION_ACTIVE_PIN) begin
            first_cal <= 1'b0;
        end
    end
    property p_mirror;
        MIRRORED_DATA_CLOCK == DATA_CLOCK_OUT;
    endproperty
    a_mirror: assert property (p_mirror) else $error("mirror clock differs");
    property p_oe_off;
        !DELAYED_BUS_OE |-> (I_DELAYED_BUS == 8'h00) && (Q_DELAYED_BUS == 8'h00);
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("delayed bus active");
    property p_ready;
        RESETN |=> PREADY;
    endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    // Outside calibration the data clock never stalls for two cycles in any mode
    property p_data_clock_out_runs;
        (!CALIBRATION_ACTIVE_PIN)[*3] ##0 $stable(DATA_CLOCK_OUT)
            |=> !$stable(DATA_CLOCK_OUT) || CALIBRATION_ACTIVE_PIN;
    endproperty
    a_data_clock_out_runs: assert property (p_data_clock_out_runs) else $error("data clock stalled");
    property p_ovr;
        fs_hi[*4] ##0 (I_VIN > 16'sd420 || I_VIN < -16'sd420) |=> OVER_RANGE;
    endproperty
    a_ovr: assert property (p_ovr) else $error("over-range missed");
    property p_clamp;
        fs_hi[*4] ##0 (I_VIN > 16'sd420)[*2] |-> ##2 (I_PROMPT_BUS == 8'hff);
    endproperty
    a_clamp: assert property (p_clamp) else $error("no full code");
    property p_cal_len;
        cal_cnt <= TRIM_CYCLES + CAL_CYCLES + 4;
    endproperty
    a_cal_len: assert property (p_cal_len) else $error("calibration too long");
    property p_trim_quiet;
        CALIBRATION_ACTIVE_PIN && first_cal && cal_cnt >= 2 && cal_cnt < TRIM_CYCLES - 1
            |-> !DATA_CLOCK_OUT;
    endproperty
    a_trim_quiet: assert property (p_trim_quiet) else $error("clock ran in trim");
    c_demux: cover property (DELAYED_BUS_OE && $rose(DATA_CLOCK_OUT));
    c_cal: cover property ($fell(CALIBRATION_ACTIVE_PIN));
    c_ovr: cover property ($rose(OVER_RANGE));
endmodule // dadp_port_sva

bind dadp_port dadp_port_sva #(.TRIM_CYCLES(TRIM_CYCLES), .CAL_CYCLES(CAL_CYCLES)) u_sva (
    .CLOCK(CLOCK), .RESETN(RESETN), .PREADY(PREADY), .I_VIN(I_VIN),
    .FULL_SCALE_SELECT_PIN(FULL_SCALE_SELECT_PIN),
    .EXTENDED_CTL_ENABLE_PIN(EXTENDED_CTL_ENABLE_PIN), .I_PROMPT_BUS(I_PROMPT_BUS),
    .I_DELAYED_BUS(I_DELAYED_BUS), .Q_DELAYED_BUS(Q_DELAYED_BUS),
    .DELAYED_BUS_OE(DELAYED_BUS_OE), .DATA_CLOCK_OUT(DATA_CLOCK_OUT),
    .MIRRORED_DATA_CLOCK(MIRRORED_DATA_CLOCK), .OVER_RANGE(OVER_RANGE),
    .CALIBRATION_ACTIVE_PIN(CALIBRATION_ACTIVE_PIN));

// *** tb/dadp_rx.sv ***
// Capture receiver that latches the buses on data clock edges
`timescale 1ns/1ps
module dadp_rx (
    input wire logic clk,
    input wire logic ddr,
    input wire logic data_clock_out,
    input wire logic [7:0] prompt,
    input wire logic [7:0] delayed,
    output logic strobe = 1'b0,
    output logic [7:0] cap_p,
    output logic [7:0] cap_d
);
    logic last = 1'b0;
    // Oversampled by a fast clock, so a paused data clock does no harm
    always @(posedge clk) begin
        last <= data_clock_out;
        strobe <= (data_clock_out && !last) || (ddr && !data_clock_out && last);
        if ((data_clock_out && !last) || (ddr && !data_clock_out && last)) begin
            cap_p <= prompt;
            cap_d <= delayed;
        end
    end
endmodule // dadp_rx

// *** tb/dadp_port_tb.sv ***
// Self-checking bench for the output demultiplex port
`timescale 1ns/1ps
`include "dadp_params.svh"
module dadp_port_tb;
    localparam int TRIM = 6;
    localparam int FS = `DADP_FS_HIGH_MV;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, err, full_scale_select_pin = 1, ece = 1, cal_req = 0;
    logic signed [15:0] vin_i = 0, vin_q = 0;
    logic [7:0] pb_i, pb_q, db_i, db_q, cap_p, cap_d;
    logic oe, data_clock_out, mirrored_data_clock, ovr, cal, irq, strobe;
    logic rnd = 0, mon = 0, demux = 0, rx_ddr = 1, seeded = 0;
    logic [5:0][15:0] h = '0;
    int bad_count = 0;
    int checks = 0;
    always #50 clk = ~clk;
    dadp_port #(.TRIM_CYCLES(TRIM), .CAL_CYCLES(8)) uut (.CLOCK(clk), .RESETN(rst_n),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .I_VIN(vin_i), .Q_VIN(vin_q),
        .FULL_SCALE_SELECT_PIN(full_scale_select_pin), .EXTENDED_CTL_ENABLE_PIN(ece), .CAL_REQUEST_PIN(cal_req),
        .I_PROMPT_BUS(pb_i), .Q_PROMPT_BUS(pb_q), .I_DELAYED_BUS(db_i), .Q_DELAYED_BUS(db_q),
        .DELAYED_BUS_OE(oe), .DATA_CLOCK_OUT(data_clock_out), .MIRRORED_DATA_CLOCK(mirrored_data_clock),
        .OVER_RANGE(ovr), .CALIBRATION_ACTIVE_PIN(cal), .IRQ(irq));
    dadp_rx u_rx (.clk(clk), .ddr(rx_ddr), .data_clock_out(data_clock_out), .prompt(pb_i), .delayed(db_i),
        .strobe(strobe), .cap_p(cap_p), .cap_d(cap_d));
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [3:0] i, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdck(input logic [3:0] i, input logic [31:0] e);
        apb(1'b0, i, 32'h0);
        chk("reg", rd, e);
    endtask
    task automatic waitcal(input logic v);
        int n;
        n = 0;
        while (cal !== v && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk("cal", cal, v);
    endtask
    task automatic toggles(input int n, output int t);
        logic p;
        t = 0;
        p = data_clock_out;
        repeat (n) begin
            @(negedge clk);
            t += int'(data_clock_out !== p);
            p = data_clock_out;
        end
    endtask
    // Expected code of the sample k edges back, high full scale
    function logic [7:0] cv(int k);
        int c;
        c = (int'($signed(h[k])) + FS / 2) * 256 / FS;
        return 8'((c < 0) ? 0 : (c > 255) ? 255 : c);
    endfunction
    // The seed goes to this process, since it draws every random sample
    always @(posedge clk) begin
        if (!seeded) begin
            void'($urandom(32'hd3bb));
            seeded = 1'b1;
        end
        h <= {h[4:0], vin_i};
        if (rnd) begin
            vin_i <= 16'(int'($urandom_range(1000)) - 500);
            vin_q <= 16'(int'($urandom_range(1000)) - 500);
        end
    end
    always @(negedge clk) begin
        if (mon && strobe && demux) begin
            chk("pair", (cap_p == cv(2) && cap_d == cv(3))
                || (cap_p == cv(3) && cap_d == cv(4)), 1);
        end else if (mon && strobe) begin
            chk("prompt", cap_p, cv(2));
        end
    end
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        test_done;
    end
    initial begin
        int t;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rdck(`DADP_IDX_CTRL, `DADP_CTRL_RESET);
        rdck(`DADP_IDX_FS_ADJ, 32'(`DADP_FS_ADJ_RESET));
        rdck(`DADP_IDX_EXT_CFG, 32'(`DADP_EXT_CFG_RESET));
        rdck(4'h6, 32'h0);
        chk("err", err, 1);
        waitcal(1'b1);
        waitcal(1'b0);
        apb(1'b1, `DADP_IDX_IRQ_EN, 32'h1);
        repeat (2) @(negedge clk);
        chk("irq", irq, 1);
        apb(1'b1, `DADP_IDX_IRQ_EN, 32'h0);
        repeat (2) @(negedge clk);
        chk("irq", irq, 0);
        apb(1'b1, `DADP_IDX_IRQ_EN, 32'h1);
        apb(1'b1, `DADP_IDX_IRQ_CLR, 32'h1);
        repeat (2) @(negedge clk);
        chk("irq", irq, 0);
        rnd <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, `DADP_IDX_CTRL, 32'(m));
            demux <= m[0];
            rx_ddr <= !m[0] || m[1];
            repeat (6) @(negedge clk);
            chk("oe", oe, m[0]);
            chk("db", {db_i, db_q} & {16{!m[0]}}, 0);
            toggles(16, t);
            chk("data_clock_out", t, (m == 3) ? 8 : 16);
            mon <= 1'b1;
            repeat (40) @(posedge clk);
            mon <= 1'b0;
        end
        rnd <= 1'b0;
        @(posedge clk);
        vin_i <= 16'sd600;
        vin_q <= 16'sd0;
        repeat (5) @(negedge clk);
        chk("pb", pb_i, 8'hff);
        chk("ovr", ovr, 1);
        @(posedge clk);
        vin_i <= -16'sd600;
        repeat (5) @(negedge clk);
        chk("pb", pb_i, 8'h00);
        @(posedge clk);
        full_scale_select_pin <= 1'b0;
        vin_i <= 16'sd250;
        repeat (6) @(negedge clk);
        chk("ovr", ovr, 0);
        apb(1'b1, `DADP_IDX_FS_ADJ, 32'h190);
        rdck(`DADP_IDX_FS_ADJ, 32'h348);
        ece <= 1'b0;
        repeat (6) @(negedge clk);
        apb(1'b1, `DADP_IDX_FS_ADJ, 32'h190);
        rdck(`DADP_IDX_FS_ADJ, 32'h190);
        repeat (3) @(negedge clk);
        chk("ovr", ovr, 1);
        @(posedge clk);
        cal_req <= 1'b1;
        waitcal(1'b1);
        repeat (2) @(negedge clk);
        toggles(TRIM - 2, t);
        chk("trim", t, 0);
        @(posedge clk);
        cal_req <= 1'b0;
        waitcal(1'b0);
        apb(1'b1, `DADP_IDX_EXT_CFG, 32'h1);
        rdck(`DADP_IDX_EXT_CFG, 32'h1);
        apb(1'b1, `DADP_IDX_CTRL, 32'h7);
        waitcal(1'b1);
        repeat (2) @(negedge clk);
        toggles(TRIM - 2, t);
        chk("run", t != 0, 1);
        waitcal(1'b0);
        test_done;
    end
endmodule // dadp_port_tb
